// ### pvbs_scheduler.sv
// Broadcast scheduler for process variables, with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - At start, incomplete stored configuration loads every setting default.
// - Holds an eight character ASCII tag naming the unit.
// - All four sent and tag char eight is slash: DP first, flow second.
// - Fewer than four sent: differential pressure is the priority variable.
// - All four, no slash: flow, DP, static pressure, temperature.
// - Several selected: priority variable goes every other broadcast cycle.
// - Set select picks cumulative sets DP, +SP, +temp, +flow.
// - Each set may append body temperature, eight selections total.
// - Set select acts only in digital link mode.
// - Mode is analog or digital link, chosen by configuration.
// - Analog mode outputs one selected variable only.
module pvbs_scheduler #(
  parameter int TAG_CHARS = pvbs_pkg::TAG_CHARS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cfg_complete,
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_cycle_start,
  output logic             o_slot_valid,
  output logic [2:0]       o_slot_var,
  output logic             o_slot_priority,
  output logic             o_digital_mode
);
  typedef struct packed {
    logic                   loaded;
    logic                   cfg_ok;
    logic                   digital;
    logic [1:0]             analog_sel;
    logic [1:0]             set_sel;
    logic                   sv_on;
    logic [TAG_CHARS*8-1:0] tag;
    logic                   prio_turn;
    logic [2:0]             rr_idx;
    logic                   slot_valid;
    logic [2:0]             slot_var;
    logic                   slot_prio;
    logic [31:0]            rdata;
  } pvbs_st_t;

  pvbs_st_t    st_reg;
  pvbs_st_t    st_next;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr;
  logic [7:0]  tag_last;
  logic        all_four;
  logic [2:0]  order [0:4];
  logic [2:0]  n_sel;
  logic [2:0]  rest_n;
  logic [2:0]  rr_pick;
  logic [2:0]  rr_wrap;

  pvbs_ahb_slave u_bus (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hready    (i_hready),
    .o_wr_en     (wr_en),
    .o_rd_en     (rd_en),
    .o_addr      (addr),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp)
  );

  assign tag_last = st_reg.tag[TAG_CHARS*8-1 -: 8];
  assign all_four = (st_reg.set_sel == pvbs_pkg::SET_ALL);

  // Priority ordering of the selected variables
  always_comb begin
    order[0] = pvbs_pkg::VAR_DP;
    order[1] = pvbs_pkg::VAR_SP;
    order[2] = pvbs_pkg::VAR_TEMP;
    order[3] = pvbs_pkg::VAR_FLOW;
    order[4] = pvbs_pkg::VAR_BODY;
    if (all_four) begin
      if (tag_last == pvbs_pkg::TAG_SLASH) begin
        order[0] = pvbs_pkg::VAR_DP;
        order[1] = pvbs_pkg::VAR_FLOW;
        order[2] = pvbs_pkg::VAR_SP;
        order[3] = pvbs_pkg::VAR_TEMP;
      end else begin
        order[0] = pvbs_pkg::VAR_FLOW;
        order[1] = pvbs_pkg::VAR_DP;
        order[2] = pvbs_pkg::VAR_SP;
        order[3] = pvbs_pkg::VAR_TEMP;
      end
    end
  end

  // Cumulative set plus optional body temperature
  assign n_sel = 3'({1'b0, st_reg.set_sel}) + 3'h1 + 3'(st_reg.sv_on);
  // Body temperature sits in slot n_sel-1 when appended
  assign rest_n = n_sel - 3'h1;
  assign rr_pick = (st_reg.rr_idx >= rest_n) ? 3'h0 : st_reg.rr_idx;
  assign rr_wrap = (rr_pick + 3'h1 >= rest_n) ? 3'h0 : rr_pick + 3'h1;

  function automatic logic [2:0] sel_at(input logic [2:0] k);
    logic [2:0] r;
    r = order[k];
    if (st_reg.sv_on && k == 3'(st_reg.set_sel) + 3'h1) begin
      r = pvbs_pkg::VAR_BODY;
    end
    return r;
  endfunction

  always_comb begin
    st_next            = st_reg;
    st_next.slot_valid = 1'b0;
    // Defaults land once on the first cycle after reset
    if (!st_reg.loaded) begin
      st_next.loaded = 1'b1;
      st_next.cfg_ok = i_cfg_complete;
      if (!i_cfg_complete) begin
        st_next.digital    = pvbs_pkg::DEF_DIGITAL;
        st_next.analog_sel = pvbs_pkg::DEF_ANALOG;
        st_next.set_sel    = pvbs_pkg::DEF_SET;
        st_next.sv_on      = pvbs_pkg::DEF_SV;
        st_next.tag        = {TAG_CHARS{pvbs_pkg::DEF_TAG_CH}};
      end
    end
    if (wr_en) begin
      case (addr)
        pvbs_pkg::OFF_CTRL: begin
          st_next.digital    = i_hwdata[pvbs_pkg::CTRL_DIGITAL_BIT];
          st_next.analog_sel = i_hwdata[pvbs_pkg::CTRL_ANALOG_LSB +: 2];
        end
        pvbs_pkg::OFF_SETSEL: begin
          st_next.set_sel = i_hwdata[pvbs_pkg::SETSEL_SET_LSB +: 2];
          st_next.sv_on   = i_hwdata[pvbs_pkg::SETSEL_SV_BIT];
        end
        pvbs_pkg::OFF_TAG_LO: st_next.tag[31:0] = i_hwdata;
        pvbs_pkg::OFF_TAG_HI: st_next.tag[63:32] = i_hwdata;
        default: st_next.tag = st_next.tag;
      endcase
    end
    st_next.rdata = pvbs_pkg::BUS_ZERO;
    if (rd_en) begin
      case (addr)
        pvbs_pkg::OFF_CTRL:   st_next.rdata = {23'h0, st_reg.cfg_ok, 2'h0,
                                               st_reg.analog_sel, 3'h0,
                                               st_reg.digital};
        pvbs_pkg::OFF_SETSEL: st_next.rdata = {29'h0, st_reg.sv_on,
                                               st_reg.set_sel};
        pvbs_pkg::OFF_TAG_LO: st_next.rdata = st_reg.tag[31:0];
        pvbs_pkg::OFF_TAG_HI: st_next.rdata = st_reg.tag[63:32];
        pvbs_pkg::OFF_STATUS: st_next.rdata = {21'h0, n_sel, 4'h0,
                                               st_reg.prio_turn, order[0]};
        pvbs_pkg::OFF_SLOT:   st_next.rdata = {27'h0, st_reg.slot_prio,
                                               1'b0, st_reg.slot_var};
        default:              st_next.rdata = pvbs_pkg::BUS_ZERO;
      endcase
    end
    if (i_cycle_start && st_reg.loaded) begin
      st_next.slot_valid = 1'b1;
      if (!st_reg.digital) begin
        // Analog output carries one variable; set select is ignored
        st_next.slot_var  = {1'b0, st_reg.analog_sel};
        st_next.slot_prio = 1'b1;
      end else if (n_sel == 3'h1 || st_reg.prio_turn) begin
        st_next.slot_var  = order[0];
        st_next.slot_prio = 1'b1;
        st_next.prio_turn = 1'b0;
      end else begin
        // Remaining variables start at second priority and rotate
        st_next.slot_var  = sel_at(rr_pick + 3'h1);
        st_next.slot_prio = 1'b0;
        st_next.rr_idx    = rr_wrap;
        st_next.prio_turn = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg            <= '0;
      st_reg.digital    <= pvbs_pkg::DEF_DIGITAL;
      st_reg.analog_sel <= pvbs_pkg::DEF_ANALOG;
      st_reg.prio_turn  <= 1'b1;
      st_reg.tag        <= {TAG_CHARS{pvbs_pkg::DEF_TAG_CH}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_hrdata        = st_reg.rdata;
  assign o_slot_valid    = st_reg.slot_valid;
  assign o_slot_var      = st_reg.slot_var;
  assign o_slot_priority = st_reg.slot_prio;
  assign o_digital_mode  = st_reg.digital;

  property p_prio_alternate;
    @(posedge i_clk) disable iff (i_rst)
      (o_slot_valid && o_digital_mode && !o_slot_priority && i_cycle_start
       && !wr_en) |=> (o_slot_valid && o_slot_priority);
  endproperty
  a_prio_alternate: assert property (p_prio_alternate)
    else $error("priority slot did not follow a non-priority slot");

  property p_flow_first;
    @(posedge i_clk) disable iff (i_rst)
      (i_cycle_start && st_reg.digital && all_four && st_reg.prio_turn
       && tag_last != pvbs_pkg::TAG_SLASH && !wr_en)
      |=> (o_slot_var == pvbs_pkg::VAR_FLOW);
  endproperty
  a_flow_first: assert property (p_flow_first)
    else $error("flow was not the priority variable");

  property p_slash_dp;
    @(posedge i_clk) disable iff (i_rst)
      (i_cycle_start && st_reg.loaded && st_reg.digital && all_four
       && tag_last == pvbs_pkg::TAG_SLASH && !wr_en
       && (st_reg.prio_turn || rr_pick == 3'h0))
      |=> (o_slot_var == ($past(st_reg.prio_turn) ? pvbs_pkg::VAR_DP
                                                  : pvbs_pkg::VAR_FLOW));
  endproperty
  a_slash_dp: assert property (p_slash_dp)
    else $error("slash marker did not promote differential pressure");

  property p_dp_default;
    @(posedge i_clk) disable iff (i_rst)
      (i_cycle_start && st_reg.loaded && st_reg.digital && !all_four
       && st_reg.prio_turn && !wr_en)
      |=> (o_slot_var == pvbs_pkg::VAR_DP && o_slot_priority);
  endproperty
  a_dp_default: assert property (p_dp_default)
    else $error("differential pressure not priority for partial set");

  property p_defaults;
    @(posedge i_clk) disable iff (i_rst)
      (!st_reg.loaded && !i_cfg_complete) |=>
        (st_reg.set_sel == pvbs_pkg::DEF_SET && !st_reg.sv_on
         && st_reg.loaded);
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("defaults not loaded for incomplete configuration");

  property p_analog_one;
    @(posedge i_clk) disable iff (i_rst)
      (i_cycle_start && st_reg.loaded && !st_reg.digital && !wr_en)
      |=> (o_slot_var == {1'b0, $past(st_reg.analog_sel)} && o_slot_priority);
  endproperty
  a_analog_one: assert property (p_analog_one)
    else $error("analog mode sent something other than its variable");

  // Variable codes follow the cumulative set order, so a compare suffices
  property p_in_set;
    @(posedge i_clk) disable iff (i_rst)
      (o_slot_valid && o_digital_mode && !$past(wr_en))
      |-> ((o_slot_var == pvbs_pkg::VAR_BODY) ? st_reg.sv_on
           : (o_slot_var <= {1'b0, st_reg.set_sel}));
  endproperty
  a_in_set: assert property (p_in_set)
    else $error("broadcast slot outside the selected set");

  property p_rr_range;
    @(posedge i_clk) disable iff (i_rst)
      (o_slot_valid && o_digital_mode && !o_slot_priority) |->
        (o_slot_var != $past(order[0], 1));
  endproperty
  a_rr_range: assert property (p_rr_range)
    else $error("round-robin slot repeated the priority variable");

  property p_slot_pulse;
    @(posedge i_clk) disable iff (i_rst)
      (i_cycle_start && st_reg.loaded) |=> o_slot_valid;
  endproperty
  a_slot_pulse: assert property (p_slot_pulse)
    else $error("broadcast cycle produced no slot");

  property p_no_slot;
    @(posedge i_clk) disable iff (i_rst)
      !(i_cycle_start && st_reg.loaded) |=> !o_slot_valid;
  endproperty
  a_no_slot: assert property (p_no_slot)
    else $error("slot produced without a broadcast cycle");

  property p_single_prio;
    @(posedge i_clk) disable iff (i_rst)
      (i_cycle_start && st_reg.loaded && st_reg.digital && n_sel == 3'h1
       && !wr_en) |=> (o_slot_priority && o_slot_var == pvbs_pkg::VAR_DP);
  endproperty
  a_single_prio: assert property (p_single_prio)
    else $error("single selected variable was not sent every cycle");

  property p_tag_default;
    @(posedge i_clk) disable iff (i_rst)
      (!st_reg.loaded && !i_cfg_complete && !wr_en) |=>
        (st_reg.tag == {TAG_CHARS{pvbs_pkg::DEF_TAG_CH}}
         && st_reg.digital == pvbs_pkg::DEF_DIGITAL
         && st_reg.analog_sel == pvbs_pkg::DEF_ANALOG);
  endproperty
  a_tag_default: assert property (p_tag_default)
    else $error("tag and mode defaults not loaded");
endmodule
`default_nettype wire

// ### pvbs_pkg.sv
// Package of constants for the process variable broadcast scheduler
`default_nettype none
package pvbs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SETSEL  = 8'h04;
  localparam logic [7:0] OFF_TAG_LO  = 8'h08;
  localparam logic [7:0] OFF_TAG_HI  = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_SLOT    = 8'h14;

  // Control register fields
  localparam int CTRL_DIGITAL_BIT = 0;
  localparam int CTRL_ANALOG_LSB  = 4;
  localparam int CTRL_VALID_BIT   = 8;
  localparam int CTRL_ADVANCE_BIT = 16;

  // Set select fields
  localparam int SETSEL_SET_LSB = 0;
  localparam int SETSEL_SV_BIT  = 2;

  // Variable codes
  localparam logic [2:0] VAR_DP   = 3'h0;
  localparam logic [2:0] VAR_SP   = 3'h1;
  localparam logic [2:0] VAR_TEMP = 3'h2;
  localparam logic [2:0] VAR_FLOW = 3'h3;
  localparam logic [2:0] VAR_BODY = 3'h4;

  // Broadcast set codes, cumulative
  localparam logic [1:0] SET_ALL = 2'h3;

  // Defaults loaded when the stored configuration is incomplete
  localparam logic       DEF_DIGITAL = 1'b1;
  localparam logic [1:0] DEF_ANALOG  = 2'h3;
  localparam logic [1:0] DEF_SET     = 2'h0;
  localparam logic       DEF_SV      = 1'b0;
  localparam logic [7:0] DEF_TAG_CH  = 8'h20;

  // Tag marker
  localparam logic [7:0] TAG_SLASH = 8'h2f;
  localparam int         TAG_CHARS = 8;

  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

endpackage
`default_nettype wire

// ### pvbs_ahb_slave.sv
// AHB-Lite slave front end: captures address phase, gives write strobe
`timescale 1ns/1ps
`default_nettype none
module pvbs_ahb_slave (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [7:0]       o_addr,
  output logic             o_hreadyout,
  output logic             o_hresp
);
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } pvbs_ahb_st_t;

  pvbs_ahb_st_t st_reg;
  pvbs_ahb_st_t st_next;
  logic         take;

  // Only word accesses count; others complete with no effect
  assign take = i_hsel & i_hready & i_htrans[1] & (i_hsize == 3'h2);

  always_comb begin
    st_next      = st_reg;
    st_next.wr   = take & i_hwrite;
    st_next.rd   = take & ~i_hwrite;
    if (take) begin
      st_next.addr = i_haddr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_wr_en     = st_reg.wr;
  assign o_rd_en     = st_reg.rd;
  assign o_addr      = st_reg.addr;
  // Reads stretch by one wait state, since read data is registered after rd
  assign o_hreadyout = ~st_reg.rd;
  assign o_hresp     = 1'b0;
endmodule
`default_nettype wire

// ### pvbs_rx_model.sv
// Model of the control system input module that takes broadcast slots
`timescale 1ns/1ps
`default_nettype none
module pvbs_rx_model (
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic       i_slot_valid,
  input  wire logic [2:0] i_slot_var,
  input  wire logic       i_slot_priority,
  output logic            o_cycle_start,
  output logic [7:0]      o_count,
  output logic [2:0]      o_var,
  output logic            o_prio
);
  initial begin
    o_cycle_start = 1'b0;
    o_count       = 8'h00;
    o_var         = 3'h7;
    o_prio        = 1'b0;
  end
  // Start pulse is launched one edge after the request, never mid-cycle
  always @(posedge i_clk) begin
    o_cycle_start <= i_req;
    if (i_slot_valid === 1'b1) begin
      o_count <= o_count + 8'h01;
      o_var   <= i_slot_var;
      o_prio  <= i_slot_priority;
    end
  end
endmodule
`default_nettype wire

// ### test_pv_broadcast_scheduler.sv
// Self-checking testbench for the broadcast scheduler
`timescale 1ns/1ps
`default_nettype none
module test_pv_broadcast_scheduler;
  logic        clk, rst, cfg, hwrite, req, cs, sv, pr, prio, mode, hresp;
  logic [1:0]  htrans;
  logic [7:0]  haddr, cnt;
  logic [31:0] hwdata, hrdata;
  logic [2:0]  var_s, var_r;
  wire logic   hrdy;
  int          n_errors, checks, cyc;

  pvbs_scheduler i_dut (.i_clk(clk), .i_rst(rst), .i_cfg_complete(cfg),
    .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_cycle_start(cs),
    .o_slot_valid(sv), .o_slot_var(var_s), .o_slot_priority(pr),
    .o_digital_mode(mode));
  pvbs_rx_model i_rx (.i_clk(clk), .i_req(req), .i_slot_valid(sv),
    .i_slot_var(var_s), .i_slot_priority(pr), .o_cycle_start(cs),
    .o_count(cnt), .o_var(var_r), .o_prio(prio));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc >= 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic reset_dut(input logic c);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= c;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("read", e, q);
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic slot(input logic [2:0] ev, input logic ep);
    logic [7:0] c;
    c = cnt;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    for (int k = 0; k < 10 && cnt === c; k++) @(posedge clk);
    chk("slot_var", 32'(ev), 32'(var_r));
    chk("slot_prio", 32'(ep), 32'(prio));
  endtask

  // Three back-to-back cycles: priority, other (priority when only one is selected), priority again
  task automatic burst(input logic [2:0] ev);
    logic [7:0] c;
    c = cnt;
    req <= 1'b1;
    repeat (3) @(posedge clk);
    req <= 1'b0;
    for (int k = 0; k < 12 && cnt !== c + 8'h03; k++) @(posedge clk);
    chk("burst_cnt", 32'(c + 8'h03), 32'(cnt));
    chk("burst_var", 32'(ev), 32'(var_r));
    chk("burst_prio", 32'h1, 32'(prio));
  endtask

  task automatic defaults();
    logic [31:0] q;
    reset_dut(1'b0);
    rd(pvbs_pkg::OFF_CTRL, 32'h31);
    rd(pvbs_pkg::OFF_SETSEL, 32'h0);
    rd(pvbs_pkg::OFF_TAG_HI, 32'h20202020);
    chk("mode", 32'h1, 32'(mode));
    bus(1'b1, pvbs_pkg::OFF_TAG_LO, 32'h41424344, q);
    rd(pvbs_pkg::OFF_TAG_LO, 32'h41424344);
    rd(8'h18, 32'h0);
    reset_dut(1'b1);
    rd(pvbs_pkg::OFF_CTRL, 32'h131);
  endtask

  // Analog mode: one chosen variable, set select has no effect
  task automatic analog();
    logic [31:0] q;
    reset_dut(1'b1);
    bus(1'b1, pvbs_pkg::OFF_SETSEL, 32'h7, q);
    bus(1'b1, pvbs_pkg::OFF_CTRL, 32'h20, q);
    repeat (3) slot(pvbs_pkg::VAR_TEMP, 1'b1);
    chk("mode", 32'h0, 32'(mode));
  endtask

  task automatic run(input int s, input bit b, input bit sl);
    logic [2:0]  l[$];
    logic [31:0] q;
    int          n;
    reset_dut(1'b1);
    bus(1'b1, pvbs_pkg::OFF_SETSEL, 32'(s) | (b ? 32'h4 : 32'h0), q);
    rd(pvbs_pkg::OFF_SETSEL, 32'(s) | (b ? 32'h4 : 32'h0));
    if (sl) bus(1'b1, pvbs_pkg::OFF_TAG_HI, 32'h2f202020, q);
    if (s == 3) begin
      l.push_back(sl ? pvbs_pkg::VAR_DP : pvbs_pkg::VAR_FLOW);
      l.push_back(sl ? pvbs_pkg::VAR_FLOW : pvbs_pkg::VAR_DP);
      l.push_back(pvbs_pkg::VAR_SP);
      l.push_back(pvbs_pkg::VAR_TEMP);
    end else begin
      for (int k = 0; k <= s; k++) l.push_back(3'(k));
    end
    if (b) l.push_back(pvbs_pkg::VAR_BODY);
    n = l.size();
    rd(pvbs_pkg::OFF_STATUS, (32'(n) << 8) | 32'h8 | 32'(l[0]));
    for (int k = 0; k < 2 * n + 2; k++) begin
      if (n == 1 || k % 2 == 0) slot(l[0], 1'b1);
      else slot(l[1 + (k / 2) % (n - 1)], 1'b0);
    end
    burst(l[0]);
    rd(pvbs_pkg::OFF_SLOT, 32'h10 | 32'(l[0]));
  endtask

  initial begin
    rst = 1'b1; cfg = 1'b0; hwrite = 1'b0; req = 1'b0;
    htrans = 2'h0; haddr = 8'h00; hwdata = 32'h0;
    n_errors = 0; checks = 0; cyc = 0;
    defaults();
    for (int s = 0; s < 4; s++)
      for (int b = 0; b < 2; b++)
        for (int sl = 0; sl < 2; sl++) run(s, b[0], sl[0]);
    analog();
    end_of_test();
  end
endmodule
`default_nettype wire
